// ### logic/msw_consts.svh
`ifndef MSW_CONSTS_SVH
`define MSW_CONSTS_SVH

// word indexes of the non-volatile map and read-only readouts
`define MSW_IDX_CFG      4'h0
`define MSW_IDX_TCL      4'h1
`define MSW_IDX_TCQ      4'h2
`define MSW_IDX_GRP      4'h3
`define MSW_IDX_SENS     4'h4
`define MSW_IDX_VOQ      4'h5
`define MSW_IDX_LOW      4'h6
`define MSW_IDX_HIGH     4'h7
`define MSW_IDX_LOCK     4'h8
`define MSW_IDX_TRIM_OSC 4'h9
`define MSW_IDX_TRIM_ADC 4'ha
`define MSW_IDX_ADC_RD   4'hb
`define MSW_IDX_DAC_RD   4'hc
`define MSW_NVM_WORDS    11

// operating_config field positions
`define MSW_CFG_REXT     9
`define MSW_CFG_OSGN     8
`define MSW_CFG_FMT_HI   7
`define MSW_CFG_FMT_LO   5
`define MSW_CFG_FLT_HI   4
`define MSW_CFG_FLT_LO   3
`define MSW_CFG_RNG_HI   2
`define MSW_CFG_RNG_LO   1
`define MSW_CFG_OEN      0
`define MSW_LOCK_BIT     0

// blank-device contents
`define MSW_RST_CFG      16'h0090
`define MSW_RST_TCL      16'h000f
`define MSW_RST_TCQ      16'h0001
`define MSW_RST_GRP      16'h0001
`define MSW_RST_SENS     16'h0800
`define MSW_RST_VOQ      16'h0000
`define MSW_RST_LOW      16'h0200
`define MSW_RST_HIGH     16'h0600
`define MSW_RST_LOCK     16'h0000

// gain is fixed point with this many fraction bits
`define MSW_GAIN_SHIFT   11

// decoded converter range in mT and filter corner in Hz
`define MSW_MT_15        8'h0f
`define MSW_MT_30        8'h1e
`define MSW_MT_40        8'h28
`define MSW_MT_60        8'h3c
`define MSW_MT_80        8'h50
`define MSW_MT_100       8'h64
`define MSW_MT_150       8'h96
`define MSW_HZ_80        12'h050
`define MSW_HZ_500       12'h1f4
`define MSW_HZ_1K        12'h3e8
`define MSW_HZ_2K        12'h7d0

`endif

// ### logic/msw_pkg.sv
`default_nettype none
package msw_pkg;
  typedef enum logic [2:0] {
    MSW_ST_CLEAR = 3'b001,
    MSW_ST_LOAD  = 3'b010,
    MSW_ST_RUN   = 3'b100
  } msw_state_t;

  typedef enum logic [2:0] {
    MSW_FMT_SW_POS = 3'b100,
    MSW_FMT_SW_INV = 3'b101
  } msw_fmt_t;
endpackage
`default_nettype wire

// ### logic/msw_nvm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msw_nvm_if #(
  parameter int DW = 16,
  parameter int NW = 11
);
  logic          we;
  logic          clr;
  logic [3:0]    addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] word [NW];

  modport ctl (output we, clr, addr, wdata, input word);
  modport mem (input we, clr, addr, wdata, output word);
endinterface
`default_nettype wire

// ### logic/msw_nvm.sv
`timescale 1ns/1ps
`default_nettype none
`include "msw_consts.svh"
module msw_nvm import msw_pkg::*; #(
  parameter int            DW       = 16,
  parameter int            NW       = 11,
  parameter logic [15:0]   TRIM_OSC = 16'h0055, // arbitrary value
  parameter logic [15:0]   TRIM_ADC = 16'h00aa  // arbitrary value
) (
  input wire logic clk_sys,
  msw_nvm_if.mem   nv
);
  // eeprom cells keep their contents across resets, so no reset here
  logic [DW-1:0] mem_ff [NW];

  if (DW != 16 || NW != `MSW_NVM_WORDS) begin : g_chk
    $error("msw_nvm: DW must be 16 and NW must match the map");
  end

  always_ff @(posedge clk_sys) begin
    if (nv.clr) begin
      mem_ff[`MSW_IDX_CFG]      <= `MSW_RST_CFG;
      mem_ff[`MSW_IDX_TCL]      <= `MSW_RST_TCL;
      mem_ff[`MSW_IDX_TCQ]      <= `MSW_RST_TCQ;
      mem_ff[`MSW_IDX_GRP]      <= `MSW_RST_GRP;
      mem_ff[`MSW_IDX_SENS]     <= `MSW_RST_SENS;
      mem_ff[`MSW_IDX_VOQ]      <= `MSW_RST_VOQ;
      mem_ff[`MSW_IDX_LOW]      <= `MSW_RST_LOW;
      mem_ff[`MSW_IDX_HIGH]     <= `MSW_RST_HIGH;
      mem_ff[`MSW_IDX_LOCK]     <= `MSW_RST_LOCK;
      mem_ff[`MSW_IDX_TRIM_OSC] <= TRIM_OSC;
      mem_ff[`MSW_IDX_TRIM_ADC] <= TRIM_ADC;
    end else if (nv.we) begin
      if (nv.addr == `MSW_IDX_LOCK) begin
        // lock bits only ever get set
        mem_ff[`MSW_IDX_LOCK] <= mem_ff[`MSW_IDX_LOCK] | nv.wdata;
      end else begin
        mem_ff[nv.addr] <= nv.wdata;
      end
    end
  end

  assign nv.word = mem_ff;
endmodule // msw_nvm
`default_nettype wire

// ### logic/msw_hyst.sv
`timescale 1ns/1ps
`default_nettype none
module msw_hyst #(
  parameter int SW = 32
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_sn,
  input  wire logic                 en,
  input  wire logic signed [SW-1:0] sig,
  input  wire logic signed [SW-1:0] thr_lo,
  input  wire logic signed [SW-1:0] thr_hi,
  output logic                      on_ff
);
  if (SW < 8) begin : g_chk
    $error("msw_hyst: SW too narrow");
  end

  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      on_ff <= 1'b0;
    end else if (en) begin
      if (sig > thr_hi) begin
        on_ff <= 1'b1;
      end else if (sig < thr_lo) begin
        on_ff <= 1'b0;
      end
      // in between the state is held
    end
  end

  a_hyst_on: assert property (
    @(posedge clk_sys) disable iff (!rst_sn)
    en && sig > thr_hi |=> on_ff)
    else $error("switch did not turn on above high level");
  a_hyst_off: assert property (
    @(posedge clk_sys) disable iff (!rst_sn)
    en && sig < thr_lo && !(sig > thr_hi) |=> !on_ff)
    else $error("switch did not turn off below low level");
  a_hyst_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_sn)
    en && sig >= thr_lo && sig <= thr_hi |=> $stable(on_ff))
    else $error("switch changed inside the hysteresis band");
endmodule // msw_hyst
`default_nettype wire

// ### logic/msw_top.sv
// What this block does
// - processing always uses stored register contents
// - signal is field times gain plus offset
// - on above high level, off below low
// - set lock never clears, refuses programming
// - lock bit zero acts after power cycle
// - unlocked: decode commands, access memory, reply
// - switching output disabled during programming exchange while unlocked
// - factory trim words read-only to customer
// - config word fields laid out bit-exact
// - offset correction plus, none, minus half
// - range bits decode to field range
// - filter bits select low-pass corner
// - format 100 positive, 101 inverted switch
// - four temperature-coefficient group codes
// - five-bit linear, three-bit quadratic coefficients
`timescale 1ns/1ps
`default_nettype none
`include "msw_consts.svh"
module msw_top import msw_pkg::*; #(
  parameter int DW = 16,
  parameter int AW = 14
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          nvm_blank,
  input  wire logic          adc_valid,
  input  wire logic [AW-1:0] adc_sample,
  input  wire logic          comm_active,
  input  wire logic          cmd_valid,
  input  wire logic          cmd_write,
  input  wire logic [3:0]    cmd_addr,
  input  wire logic [DW-1:0] cmd_wdata,
  output logic               rsp_valid,
  output logic               rsp_err,
  output logic [DW-1:0]      rsp_data,
  output logic               out_pin,
  output logic               out_en,
  output logic               locked,
  output logic [7:0]         range_mt,
  output logic [11:0]        filter_hz,
  output logic [1:0]         tc_group,
  output logic [4:0]         temp_coeff_linear,
  output logic [2:0]         temp_coeff_quadratic
);
  localparam int SW = AW + DW + 2;
  localparam logic signed [AW:0] HALF_FS = (AW+1)'(2 ** (AW - 1));

  if (DW != 16 || AW < 8 || AW > DW) begin : g_chk
    $error("msw_top: DW must be 16 and AW in 8..16");
  end

  logic          rst_q1_ff;
  logic          rst_q2_ff;
  logic          rst_sn;
  msw_state_t    state_ff;
  logic          lock_live_ff;
  logic [AW-1:0] adc_ff;
  logic signed [SW-1:0] sig_ff;
  logic          rsp_valid_ff;
  logic          rsp_err_ff;
  logic [DW-1:0] rsp_data_ff;
  logic          out_pin_ff;
  logic          out_en_ff;
  logic          sw_on;

  msw_nvm_if #(.DW(DW), .NW(`MSW_NVM_WORDS)) nv ();

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1_ff <= 1'b0;
      rst_q2_ff <= 1'b0;
    end else begin
      rst_q1_ff <= 1'b1;
      rst_q2_ff <= rst_q1_ff;
    end
  end
  assign rst_sn = rst_q2_ff;

  // start-up: optional blank fill, then latch the stored lock bit
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      state_ff <= MSW_ST_CLEAR;
    end else begin
      case (state_ff)
        MSW_ST_CLEAR: state_ff <= MSW_ST_LOAD;
        MSW_ST_LOAD:  state_ff <= MSW_ST_RUN;
        MSW_ST_RUN:   state_ff <= MSW_ST_RUN;
        default:      state_ff <= MSW_ST_CLEAR;
      endcase
    end
  end

  // lock is only sampled once per power-up, so a fresh lock waits
  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      lock_live_ff <= 1'b0;
    end else if (state_ff == MSW_ST_LOAD) begin
      lock_live_ff <= nv.word[`MSW_IDX_LOCK][`MSW_LOCK_BIT];
    end
  end

  // command decode
  logic          run;
  logic          accept;
  logic          wr_ok;
  logic          rd_ok;
  logic [DW-1:0] rd_val;

  assign run    = (state_ff == MSW_ST_RUN);
  assign accept = cmd_valid && run && !lock_live_ff;
  // trim words sit above the lock index and are never writable
  assign wr_ok  = (cmd_addr <= `MSW_IDX_LOCK);
  assign rd_ok  = (cmd_addr <= `MSW_IDX_DAC_RD);

  assign nv.clr   = (state_ff == MSW_ST_CLEAR) && nvm_blank;
  assign nv.we    = accept && cmd_write && wr_ok;
  assign nv.addr  = cmd_addr;
  assign nv.wdata = cmd_wdata;

  always_comb begin
    rd_val = '0;
    if (cmd_addr == `MSW_IDX_ADC_RD) begin
      rd_val = DW'($signed(adc_ff));
    end else if (cmd_addr == `MSW_IDX_DAC_RD) begin
      rd_val = sig_ff[DW-1:0];
    end else if (cmd_addr < 4'(`MSW_NVM_WORDS)) begin
      rd_val = nv.word[cmd_addr];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff   <= 1'b0;
      rsp_data_ff  <= '0;
    end else begin
      rsp_valid_ff <= accept;
      if (accept) begin
        rsp_err_ff  <= cmd_write ? !wr_ok : !rd_ok;
        rsp_data_ff <= cmd_write ? cmd_wdata : rd_val;
      end
    end
  end

  msw_nvm #(
    .DW(DW),
    .NW(`MSW_NVM_WORDS)
  ) u_nvm (
    .clk_sys(clk_sys),
    .nv     (nv)
  );

  // signal path, evaluated from live register contents every cycle
  logic [DW-1:0]        cfg_w;
  logic signed [AW:0]   offs;
  logic signed [AW:0]   corr;
  logic signed [AW+DW:0] prod;
  logic signed [SW-1:0] sig_comb;
  logic signed [SW-1:0] thr_lo;
  logic signed [SW-1:0] thr_hi;

  assign cfg_w = nv.word[`MSW_IDX_CFG];

  always_comb begin
    case ({cfg_w[`MSW_CFG_OSGN], cfg_w[`MSW_CFG_OEN]})
      2'b01:   offs = HALF_FS;
      2'b11:   offs = -HALF_FS;
      default: offs = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      adc_ff <= '0;
    end else if (adc_valid) begin
      adc_ff <= adc_sample;
    end
  end

  assign corr = $signed({adc_ff[AW-1], adc_ff}) + offs;
  // product width covers the full gain span, no saturation needed
  assign prod = corr * $signed(nv.word[`MSW_IDX_SENS]);
  assign sig_comb = SW'(prod >>> `MSW_GAIN_SHIFT)
                  + SW'($signed(nv.word[`MSW_IDX_VOQ]));
  assign thr_lo = $signed({{(SW-DW){1'b0}}, nv.word[`MSW_IDX_LOW]});
  assign thr_hi = $signed({{(SW-DW){1'b0}}, nv.word[`MSW_IDX_HIGH]});

  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      sig_ff <= '0;
    end else begin
      sig_ff <= sig_comb;
    end
  end

  msw_hyst #(.SW(SW)) u_hyst (
    .clk_sys(clk_sys),
    .rst_sn (rst_sn),
    .en     (run),
    .sig    (sig_ff),
    .thr_lo (thr_lo),
    .thr_hi (thr_hi),
    .on_ff  (sw_on)
  );

  // output stage: on pulls low unless the format inverts it
  logic fmt_inv;
  assign fmt_inv = (cfg_w[`MSW_CFG_FMT_HI:`MSW_CFG_FMT_LO] == MSW_FMT_SW_INV);

  always_ff @(posedge clk_sys or negedge rst_sn) begin
    if (!rst_sn) begin
      out_pin_ff <= 1'b1;
      out_en_ff  <= 1'b0;
    end else begin
      out_pin_ff <= sw_on ? fmt_inv : !fmt_inv;
      // once locked, supply modulation is ignored and never mutes it
      out_en_ff  <= run && !(comm_active && !lock_live_ff);
    end
  end

  // configuration decode towards the front end
  always_comb begin
    case ({cfg_w[`MSW_CFG_REXT], cfg_w[`MSW_CFG_RNG_HI:`MSW_CFG_RNG_LO]})
      3'b100:  range_mt = `MSW_MT_15;
      3'b000:  range_mt = `MSW_MT_30;
      3'b110:  range_mt = `MSW_MT_40;
      3'b001:  range_mt = `MSW_MT_60;
      3'b010:  range_mt = `MSW_MT_80;
      3'b011:  range_mt = `MSW_MT_100;
      3'b111:  range_mt = `MSW_MT_150;
      default: range_mt = 8'h00; // 1/01 has no defined range
    endcase
  end

  always_comb begin
    case (cfg_w[`MSW_CFG_FLT_HI:`MSW_CFG_FLT_LO])
      2'b00:   filter_hz = `MSW_HZ_80;
      2'b10:   filter_hz = `MSW_HZ_500;
      2'b11:   filter_hz = `MSW_HZ_1K;
      default: filter_hz = `MSW_HZ_2K;
    endcase
  end

  assign tc_group             = nv.word[`MSW_IDX_GRP][1:0];
  assign temp_coeff_linear    = nv.word[`MSW_IDX_TCL][4:0];
  assign temp_coeff_quadratic = nv.word[`MSW_IDX_TCQ][2:0];

  assign rsp_valid = rsp_valid_ff;
  assign rsp_err   = rsp_err_ff;
  assign rsp_data  = rsp_data_ff;
  assign out_pin   = out_pin_ff;
  assign out_en    = out_en_ff;
  assign locked    = lock_live_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_sn);

  a_lock_refuse: assert property (lock_live_ff |-> !nv.we)
    else $error("programming accepted while locked");
  a_lock_sticky: assert property (
    run && $past(nv.word[`MSW_IDX_LOCK][`MSW_LOCK_BIT])
    |-> nv.word[`MSW_IDX_LOCK][`MSW_LOCK_BIT])
    else $error("stored lock bit was cleared");
  a_lock_deferred: assert property (
    run && !lock_live_ff ##1 run |-> !lock_live_ff)
    else $error("lock took effect without a power cycle");
  a_cmd_reply: assert property (
    cmd_valid && run && !lock_live_ff |=> rsp_valid)
    else $error("accepted command not answered in one cycle");
  a_cmd_quiet: assert property (
    !(cmd_valid && run && !lock_live_ff) |=> !rsp_valid)
    else $error("reply without an accepted command");
  a_comm_mute: assert property (
    comm_active && run && !lock_live_ff |=> !out_en)
    else $error("switch output active during programming");
  a_trim_ro: assert property (
    nv.we |-> nv.addr != `MSW_IDX_TRIM_OSC && nv.addr != `MSW_IDX_TRIM_ADC)
    else $error("factory trim word written");
  a_pol_out: assert property (
    run ##1 run |-> out_pin == ($past(sw_on) ? $past(fmt_inv)
                                            : !$past(fmt_inv)))
    else $error("output level does not follow switch and format");
  a_offset_half: assert property (
    {cfg_w[`MSW_CFG_OSGN], cfg_w[`MSW_CFG_OEN]} == 2'b11
    |-> corr == $signed({adc_ff[AW-1], adc_ff}) - HALF_FS)
    else $error("negative offset correction wrong");
  // unity gain with no offsets must pass the field value straight through
  a_gain_path: assert property (
    nv.word[`MSW_IDX_SENS] == 16'h0800 && nv.word[`MSW_IDX_VOQ] == '0
    && !cfg_w[`MSW_CFG_OEN]
    |=> sig_ff == SW'($past($signed(adc_ff))))
    else $error("unity gain path does not pass the field value");

  c_switch_on: cover property (!sw_on ##1 sw_on);
  c_write_read: cover property (accept && cmd_write ##[1:20] accept);
  c_locked_boot: cover property (run && lock_live_ff);
  c_comm_mute: cover property (out_en ##1 !out_en);
endmodule // msw_top
`default_nettype wire

// ### bench/msw_prog.sv
`timescale 1ns/1ps
`default_nettype none
module msw_prog (
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_err,
  input  wire logic [15:0] rsp_data,
  input  wire logic        out_en,
  output logic             comm_active,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [3:0]       cmd_addr,
  output logic [15:0]      cmd_wdata
);
  initial begin
    comm_active = 1'b0;
    cmd_valid   = 1'b0;
    cmd_write   = 1'b0;
    cmd_addr    = 4'h0;
    cmd_wdata   = 16'h0000;
  end

  // one frame; idle lines carry inverted data so a stale word never matches
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d, output logic got,
                      output logic e, output logic [15:0] q,
                      output logic oe);
    @(negedge clk_sys);
    comm_active <= 1'b1;
    repeat (2) @(negedge clk_sys);
    oe = out_en;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr  <= a;
    cmd_wdata <= d;
    @(negedge clk_sys);
    got = rsp_valid;
    e   = rsp_err;
    q   = rsp_data;
    cmd_valid   <= 1'b0;
    cmd_write   <= ~w;
    cmd_addr    <= ~a;
    cmd_wdata   <= ~d;
    comm_active <= 1'b0;
  endtask
endmodule // msw_prog
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys, rst_n, nvm_blank, adc_valid;
  logic [13:0] adc_sample;
  logic        comm_active, cmd_valid, cmd_write;
  logic [3:0]  cmd_addr;
  logic [15:0] cmd_wdata, rsp_data, d1, d2, q;
  logic        rsp_valid, rsp_err, out_pin, out_en, locked, g, e, o;
  logic [7:0]  range_mt;
  logic [11:0] filter_hz;
  logic [1:0]  tc_group;
  logic [4:0]  temp_coeff_linear;
  logic [2:0]  temp_coeff_quadratic;
  logic [15:0] mem [16];
  logic [31:0] seed;
  int          err_total, checks_done;
  bit          on, known;
  logic [7:0]  rng [8] = '{8'h1e, 8'h3c, 8'h50, 8'h64,
                           8'h0f, 8'h00, 8'h28, 8'h96};
  logic [11:0] flt [4] = '{12'h050, 12'h7d0, 12'h1f4, 12'h3e8};
  logic [15:0] sp [3][3] = '{'{16'h0090, 16'h0800, 16'h0000},
                             '{16'h00b1, 16'h0400, 16'h0000},
                             '{16'h0191, 16'hf800, 16'he000}};
  int          pts [$] = '{0, 2000, 600, 0, 600};

  msw_top msw_top_inst (.clk_sys, .rst_n, .nvm_blank, .adc_valid,
    .adc_sample, .comm_active, .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata, .rsp_valid, .rsp_err, .rsp_data, .out_pin, .out_en,
    .locked, .range_mt, .filter_hz, .tc_group, .temp_coeff_linear,
    .temp_coeff_quadratic);

  msw_prog msw_prog_inst (.clk_sys, .rsp_valid, .rsp_err, .rsp_data,
    .out_en, .comm_active, .cmd_valid, .cmd_write, .cmd_addr,
    .cmd_wdata);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'($signed(seed[13:0]));
  endfunction

  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic power(input logic blank);
    @(negedge clk_sys);
    rst_n     <= 1'b0;
    nvm_blank <= blank;
    repeat (5) @(negedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk_sys);
    on    = 1'b0;
    known = 1'b0;
  endtask

  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [15:0] d);
    logic        rg, re, ro;
    logic [15:0] rq;
    msw_prog_inst.xfer(w, a, d, rg, re, rq, ro);
    chk(rg, 1, "reply");
    chk(ro, 0, "enable in frame");
    chk(re, w ? (a > 8) : (a > 12), "refusal");
    chk(rq, w ? d : (a > 12 ? 16'h0 : mem[a]), "data");
    if (w && a < 9)
      mem[a] = (a == 8) ? (mem[8] | d) : d;
  endtask

  task automatic step(input int adc, input bit rd);
    int offs, sig;
    bit pin;
    @(negedge clk_sys);
    adc_sample <= adc[13:0];
    adc_valid  <= 1'b1;
    @(negedge clk_sys);
    adc_valid  <= 1'b0;
    adc_sample <= ~adc[13:0];
    repeat (5) @(negedge clk_sys);
    offs = !mem[0][0] ? 0 : (mem[0][8] ? -8192 : 8192);
    sig = ((adc + offs) * int'($signed(mem[4]))) >>> 11;
    sig = sig + int'($signed(mem[5]));
    if (sig > int'(mem[7])) begin
      on    = 1'b1;
      known = 1'b1;
    end else if (sig < int'(mem[6])) begin
      on    = 1'b0;
      known = 1'b1;
    end
    // parameter writes can flip the state mid-way, so skip until settled
    pin = (mem[0][7:5] == 3'b101) ? on : !on;
    if (known)
      chk(out_pin, pin, "switch");
    chk(out_en, 1, "enable idle");
    if (rd) begin
      mem[11] = adc[15:0];
      acc(1'b0, 4'hb, 16'h0000);
      mem[12] = sig[15:0];
      acc(1'b0, 4'hc, 16'h0000);
    end
  endtask

  initial begin
    rst_n       = 1'b0;
    nvm_blank   = 1'b1;
    adc_valid   = 1'b0;
    adc_sample  = 14'h0000;
    seed        = 32'd43924;
    err_total   = 0;
    checks_done = 0;
    mem = '{16'h0090, 16'h000f, 16'h0001, 16'h0001, 16'h0800, 16'h0000,
            16'h0200, 16'h0600, 16'h0000, 16'h0055, 16'h00aa, 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'h0000};
    power(1'b1);
    chk(locked, 0, "unlocked");
    for (int i = 0; i < 11; i++)
      acc(1'b0, 4'(i), 16'h0000);
    chk(range_mt, 8'h1e, "blank range");
    chk(filter_hz, 12'h1f4, "blank filter");
    chk(tc_group, 1, "blank group");
    $display("test defaults done");
    acc(1'b1, 4'h9, 16'h1234);
    acc(1'b1, 4'ha, 16'h4321);
    acc(1'b1, 4'hf, 16'h00ff);
    for (int i = 9; i < 16; i++)
      if (i != 11 && i != 12)
        acc(1'b0, 4'(i), 16'h0000);
    $display("test read-only done");
    for (int i = 0; i < 8; i++) begin
      d1 = 16'h0080;
      d1[9] = i[2];
      d1[2:1] = i[1:0];
      d1[4:3] = i[1:0];
      acc(1'b1, 4'h0, d1);
      chk(range_mt, rng[i], "range");
      chk(filter_hz, flt[i[1:0]], "filter");
    end
    for (int k = 0; k < 4; k++) begin
      d1 = 16'(rnd() & 31);
      d2 = 16'(rnd() & 7);
      acc(1'b1, 4'h3, 16'(k));
      acc(1'b1, 4'h1, d1);
      acc(1'b1, 4'h2, d2);
      chk(tc_group, k, "group");
      chk(temp_coeff_linear, d1, "linear");
      chk(temp_coeff_quadratic, d2, "quadratic");
    end
    $display("test decode done");
    for (int k = 0; k < 3; k++) begin
      acc(1'b1, 4'h0, sp[k][0]);
      acc(1'b1, 4'h4, sp[k][1]);
      acc(1'b1, 4'h5, sp[k][2]);
      acc(1'b1, 4'h6, 16'h0200);
      acc(1'b1, 4'h7, 16'h0600);
      known = 1'b0;
      foreach (pts[i])
        step(pts[i], 1'b1);
      repeat (10)
        step(rnd(), 1'b1);
    end
    $display("test switching done");
    acc(1'b1, 4'h8, 16'h0002);
    acc(1'b1, 4'h8, 16'h0001);
    acc(1'b1, 4'h8, 16'h0000);
    acc(1'b0, 4'h8, 16'h0000);
    chk(locked, 0, "lock deferred");
    power(1'b0);
    chk(locked, 1, "lock active");
    msw_prog_inst.xfer(1'b1, 4'h0, 16'h0000, g, e, q, o);
    chk(g, 0, "ignored");
    chk(o, 1, "frame ignored");
    step(0, 1'b0);
    step(-2000, 1'b0);
    $display("test lock done");
    test_done();
  end

  initial begin
    #2000000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule // tb
`default_nettype wire
